// [olx_exec.sv]
// Decode and execute of OR-literal, OR-register, pointer load and register copy
//
// Overview of operation
// - OR literal into accumulator, set N and Z
// - OR accumulator with file, to chosen destination
// - Destination bit 0 writes accumulator only
// - Destination bit 1 writes file register back
// - Bank bit 0 uses fixed access window
// - Bank bit 1 uses bank pointer above address
// - Extended set, bank 0, low address: indexed
// - Pointer load: high part first, low second
// - Two-bit field picks pointer; flags untouched
// - Copy passes file value to chosen destination
// - Copy reads any bank byte, sets N and Z
`timescale 1ns/1ps
module olx_exec #(
  parameter int ADDR_W = 12  // File memory address width
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  // Architectural state
  logic [7:0]        accQ;         // Accumulator
  logic [3:0]        bankQ;        // Bank pointer, upper nibble reads zero
  logic [11:0]       ptrQ [0:2];   // Indirect pointers
  logic              extQ;         // Extended instruction set enable
  logic              nFlagQ;       // Result MSB flag
  logic              zFlagQ;       // All-clear flag
  logic              badQ;         // Undecodable word seen
  logic [31:0]       instrQ;       // Launched words: [15:0] first, [31:16] second
  logic [ADDR_W-1:0] maddrQ;       // Software window into file memory
  // Pipeline state across the quarter phases
  logic [3:0]        opQ;          // Decoded class: lit, reg, copy, ptr
  logic [7:0]        opndQ;        // Operand read in Q2
  logic [7:0]        resQ;         // Result formed in Q3
  // Sequencer and memory wiring
  logic [3:0]        phase;
  logic              second;
  logic              busy;
  logic              ramWe;
  logic [ADDR_W-1:0] ramAddr;
  logic [7:0]        ramWdata;
  logic [7:0]        ramRdata;
  logic [ADDR_W-1:0] execAddr;

  // Decode helpers on the first word
  logic [15:0] word1;
  logic [7:0]  fAddr;
  logic        dBit;
  logic        aBit;
  logic        q1, q2, q3, q4;
  assign word1 = instrQ[15:0];
  assign fAddr = word1[7:0];
  assign dBit  = word1[olx_pkg::OLX_DEST_BIT];
  assign aBit  = word1[olx_pkg::OLX_BANKS_BIT];
  assign q1 = phase[0];
  assign q2 = phase[1];
  assign q3 = phase[2];
  assign q4 = phase[3];

  // Instruction class from a 16-bit word; used at launch and in Q1
  function automatic logic [3:0] classOf(input logic [15:0] w);
    classOf = {w[15:6] == olx_pkg::OLX_LDPTR_OP,
               w[15:10] == olx_pkg::OLX_COPY_OP,
               w[15:10] == olx_pkg::OLX_ORREG_OP,
               w[15:8] == olx_pkg::OLX_ORLIT_OP};
  endfunction

  // Effective file address from the 8-bit field and addressing mode
  function automatic logic [ADDR_W-1:0] resolveAddr(input logic [7:0] f, input logic a,
                                                    input logic ext, input logic [3:0] bank,
                                                    input logic [11:0] idx);
    logic [11:0] full;
    full = 12'h000;
    if (a) begin
      full = {bank, f};
    end else if (ext && f <= olx_pkg::OLX_INDEX_MAX) begin
      full = idx + {4'h0, f};
    end else if (f >= olx_pkg::OLX_ACCESS_SPLIT) begin
      full = {olx_pkg::OLX_ACCESS_HIGH, f};
    end else begin
      full = {olx_pkg::OLX_ACCESS_LOW, f};
    end
    resolveAddr = full[ADDR_W-1:0];
  endfunction

  assign execAddr = resolveAddr(fAddr, aBit, extQ, bankQ, ptrQ[2]);

  // APB decode; the slave stalls every access while an instruction runs
  logic apbAcc;
  logic apbWr;
  logic apbRd;
  logic mapped;
  logic launch;
  assign pready = !busy;
  assign apbAcc = psel && penable && pready;
  assign apbWr  = apbAcc && pwrite;
  assign apbRd  = apbAcc && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= olx_pkg::OLX_MDATA_OFS);
  assign launch = apbWr && paddr == olx_pkg::OLX_INSTR_OFS;

  olx_phase_seq u_seq (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .start    (launch),
    .twoCycle (classOf(pwdata[15:0]) == 4'b1000),
    .phase    (phase),
    .second   (second),
    .busy     (busy)
  );

  // Memory port: software window when idle, instruction address when busy
  assign ramAddr  = busy ? execAddr : maddrQ;
  assign ramWe    = busy ? (q4 && (opQ[1] || opQ[2]) && dBit)
                         : (apbWr && paddr == olx_pkg::OLX_MDATA_OFS);
  assign ramWdata = busy ? resQ : pwdata[7:0];

  olx_file_ram #(.ADDR_W(ADDR_W)) u_ram (
    .ref_clk (ref_clk),
    .we      (ramWe),
    .addr    (ramAddr),
    .wdata   (ramWdata),
    .rdata   (ramRdata)
  );

  // Launched words held for the whole instruction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instrQ <= 32'h0000_0000;
    end else if (launch) begin
      instrQ <= pwdata;
    end
  end

  // Q1: decode into the class register, undecodable words become no-ops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opQ  <= 4'h0;
      badQ <= 1'b0;
    end else if (q1 && !second) begin
      opQ  <= classOf(word1);
      badQ <= classOf(word1) == 4'h0;
    end
  end

  // Q2: operand read, literal byte, pointer part or file byte
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opndQ <= 8'h00;
    end else if (q2) begin
      if (opQ[0]) begin
        opndQ <= word1[7:0];
      end else if (opQ[3]) begin
        opndQ <= second ? instrQ[23:16] : {4'h0, word1[3:0]};
      end else begin
        opndQ <= ramRdata;
      end
    end
  end

  // Q3: OR forms or pass-through for copy and pointer parts
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      resQ <= 8'h00;
    end else if (q3) begin
      if (opQ[0] || opQ[1]) begin
        resQ <= accQ | opndQ;
      end else begin
        resQ <= opndQ;
      end
    end
  end

  // Accumulator: Q4 result or software write while idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      accQ <= olx_pkg::OLX_ACC_RST;
    end else if (q4 && opQ[0]) begin
      accQ <= resQ;
    end else if (q4 && (opQ[1] || opQ[2]) && !dBit) begin
      accQ <= resQ;
    end else if (apbWr && paddr == olx_pkg::OLX_ACC_OFS) begin
      accQ <= pwdata[7:0];
    end
  end

  // Flags: the OR and copy forms or a software STATUS write set them, pointer load leaves them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nFlagQ <= 1'b0;
      zFlagQ <= 1'b0;
    end else if (q4 && (opQ[0] || opQ[1] || opQ[2])) begin
      nFlagQ <= resQ[7];
      zFlagQ <= resQ == 8'h00;
    end else if (apbWr && paddr == olx_pkg::OLX_STATUS_OFS) begin
      nFlagQ <= pwdata[olx_pkg::OLX_NEG_BIT];
      zFlagQ <= pwdata[olx_pkg::OLX_ZERO_BIT];
    end
  end

  // Pointer registers; field value 3 selects nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        ptrQ[i] <= olx_pkg::OLX_PTR_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (q4 && opQ[3] && word1[5:4] == 2'(i)) begin
          if (second) begin
            ptrQ[i][7:0] <= resQ;
          end else begin
            ptrQ[i][11:8] <= resQ[3:0];
          end
        end else if (apbWr && paddr == olx_pkg::OLX_PTR0_OFS + 8'(4 * i)) begin
          ptrQ[i] <= pwdata[11:0];
        end
      end
    end
  end

  // Software-only configuration: bank pointer, extended set, memory window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bankQ  <= olx_pkg::OLX_BANK_RST;
      extQ   <= 1'b0;
      maddrQ <= '0;
    end else if (apbWr) begin
      if (paddr == olx_pkg::OLX_BANK_OFS) begin
        bankQ <= pwdata[3:0];
      end
      if (paddr == olx_pkg::OLX_CTRL_OFS) begin
        extQ <= pwdata[olx_pkg::OLX_EXT_BIT];
      end
      if (paddr == olx_pkg::OLX_MADDR_OFS) begin
        maddrQ <= pwdata[ADDR_W-1:0];
      end
    end
  end

  // Read mux; narrow registers zero-extend
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      olx_pkg::OLX_CTRL_OFS:   prdata = {31'h0, extQ};
      olx_pkg::OLX_INSTR_OFS:  prdata = instrQ;
      olx_pkg::OLX_STATUS_OFS: prdata = {28'h0, badQ, busy, zFlagQ, nFlagQ};
      olx_pkg::OLX_ACC_OFS:    prdata = {24'h0, accQ};
      olx_pkg::OLX_BANK_OFS:   prdata = {28'h0, bankQ};
      olx_pkg::OLX_PTR0_OFS:          prdata = {20'h0, ptrQ[0]};
      olx_pkg::OLX_PTR0_OFS + 8'h04:  prdata = {20'h0, ptrQ[1]};
      olx_pkg::OLX_PTR0_OFS + 8'h08:  prdata = {20'h0, ptrQ[2]};
      olx_pkg::OLX_MADDR_OFS:  prdata = 32'(maddrQ);
      olx_pkg::OLX_MDATA_OFS:  prdata = {24'h0, ramRdata};
      default:                 prdata = 32'h0000_0000;
    endcase
  end

  // Error answer only for unmapped addresses, in the access phase
  assign pslverr = apbAcc && !mapped;

  // Checks on the running instruction; all live in the core clock domain
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Launch walks the four quarter phases in order, one per edge
  phase_order_a: assert property (launch |=> q1 ##1 q2 ##1 q3 ##1 q4)
    else $error("quarter phases out of order");

  // Literal OR lands in the accumulator one edge after Q4
  or_literal_a: assert property (
      q3 && opQ[0] |=> ##1 accQ == ($past(accQ, 2) | $past(opndQ, 2)))
    else $error("OR literal result wrong");

  // Register OR forms accumulator OR file byte in Q3
  or_register_a: assert property (
      q3 && opQ[1] |=> resQ == ($past(accQ) | $past(opndQ)))
    else $error("OR register result wrong");

  // Both flags follow the written result, never the old value
  flag_update_a: assert property (
      (q4 && (opQ[0] || opQ[1] || opQ[2]))
      |=> nFlagQ == $past(resQ[7]) && zFlagQ == ($past(resQ) == 8'h00))
    else $error("N or Z not taken from result");

  // Destination 0: accumulator takes the result, file untouched
  dest_acc_a: assert property (
      q4 && opQ[1] && !dBit |=> accQ == $past(resQ) && !$past(ramWe))
    else $error("destination 0 misrouted");

  // Destination 1: file written back, accumulator kept
  dest_file_a: assert property (
      q4 && (opQ[1] || opQ[2]) && dBit |-> ramWe ##1 $stable(accQ))
    else $error("destination 1 misrouted");

  // Copy to destination 0 hands the file byte to the accumulator
  copy_dest_a: assert property (
      q4 && opQ[2] && !dBit |=> accQ == $past(resQ) && !$past(ramWe))
    else $error("copy destination 0 misrouted");

  // Banked form glues the bank pointer above the address field
  bank_sel_a: assert property (
      busy && aBit |-> ramAddr == ADDR_W'({bankQ, fAddr}))
    else $error("banked address wrong");

  // Indexed form offsets from pointer 2, wrapping at the top
  indexed_a: assert property (
      busy && !aBit && extQ && fAddr <= olx_pkg::OLX_INDEX_MAX
      |-> ramAddr == ADDR_W'(ptrQ[2] + {4'h0, fAddr}))
    else $error("indexed address wrong");

  // Fixed window: low half at page 0, high half at the top page
  access_win_a: assert property (
      busy && !aBit && !(extQ && fAddr <= olx_pkg::OLX_INDEX_MAX)
      |-> ramAddr[7:0] == fAddr && ramAddr[ADDR_W-1:8] == (fAddr[7] ? '1 : '0))
    else $error("access window address wrong");

  // Pointer load leaves both flags as they were
  ptr_flags_a: assert property (
      q4 && opQ[3] |=> $stable(nFlagQ) && $stable(zFlagQ))
    else $error("pointer load touched flags");

  // High part lands in the first cycle, low part in the second
  ptr_high_a: assert property (
      q4 && opQ[3] && !second && word1[5:4] == 2'd2
      |=> ptrQ[2][11:8] == $past(word1[3:0]) ##4 ptrQ[2][7:0] == $past(instrQ[23:16], 4))
    else $error("pointer load order wrong");

  // Pointer field 3 names no register, so none of them moves
  ptr_none_a: assert property (
      q4 && opQ[3] && word1[5:4] == 2'd3
      |=> $stable(ptrQ[0]) && $stable(ptrQ[1]) && $stable(ptrQ[2]))
    else $error("pointer field 3 wrote a pointer");

  // Copy passes the operand through Q3 untouched
  copy_pass_a: assert property (
      q3 && opQ[2] |=> resQ == $past(opndQ))
    else $error("copy altered value");
endmodule // olx_exec

// [olx_exec_bench.sv]
// Self-checking bench for the OR, copy and pointer-load execute block
`timescale 1ns/1ps
module olx_exec_bench;
  logic        ref_clk;      // 100 MHz core clock
  logic        rstn;         // Async reset, active low
  logic [7:0]  paddr;        // APB byte address
  logic        psel;         // APB select
  logic        penable;      // APB access phase
  logic        pwrite;       // APB direction
  logic [31:0] pwdata;       // APB write data
  logic [31:0] prdata;       // APB read data
  logic        pready;       // Low while an instruction runs
  logic        pslverr;      // Unmapped access
  int          errors;       // Mismatch count
  int          comparisons;  // Compare count
  integer      seed;         // Random seed
  logic [31:0] rd;           // Last read data
  logic        err;          // Last error response
  logic [31:0] r1;           // Random words
  logic [31:0] r2;
  // Reference model state
  logic [7:0]  acc;
  logic [3:0]  bank;
  logic [11:0] ptr [3];
  logic [1:0]  flags;        // {Z, N}
  logic        ext;
  logic [7:0]  f;            // File address field
  logic [7:0]  k;            // Literal
  logic [7:0]  mv;           // File byte
  logic [7:0]  res;          // Expected result
  logic        av;           // Bank-select bit
  logic        dv;           // Destination bit
  logic [15:0] w1;           // First instruction word
  int          op;

  olx_exec u_olx_exec (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Four-state compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    // Bounded wait: a stuck slave must not hang the run
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 60) begin
      errors++;
      $display("[FAIL] %0t bus wait timed out", $time);
      close_out();
    end
  endtask

  // Read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Launch a word pair and count the cycles pready stays low
  task automatic exec(input logic [31:0] word, input int cyc);
    int n;
    apb(1'b1, olx_pkg::OLX_INSTR_OFS, word);
    #1;
    n = 0;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n, cyc);
    // A sequencer that never finishes ends the run here
    if (n >= 20) begin
      $display("[FAIL] %0t instruction never finished", $time);
      close_out();
    end
  endtask

  // Model of the file address resolution
  function automatic logic [11:0] faddr(input logic [7:0] fa, input logic a);
    if (a) return {bank, fa};
    if (ext && fa <= 8'h5F) return ptr[2] + {4'h0, fa};
    return (fa < 8'h80) ? {4'h0, fa} : {4'hF, fa};
  endfunction

  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    comparisons = 0;
    seed = 32'h7AFB33BA;
    ext = 1'b0;
    bank = 4'h0;
    ptr = '{12'h000, 12'h000, 12'h000};
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values
    rdchk(olx_pkg::OLX_ACC_OFS, 32'h0);
    rdchk(olx_pkg::OLX_BANK_OFS, 32'h0);
    for (int j = 0; j < 3; j++) rdchk(8'(olx_pkg::OLX_PTR0_OFS + 4 * j), 32'h0);
    // Unmapped place: refused both ways
    apb(1'b1, 8'h2C, 32'hFFFFFFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h2C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Byte ops over every mix of bank bit, extended set, destination and range
    for (int i = 0; i < 24; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      op = i % 3;
      av = i[0];
      ext = i[1];
      dv = i[3];
      // Small addresses reach the indexed window
      f = i[2] ? {2'b00, r1[5:0]} : r1[7:0];
      k = r1[15:8];
      mv = r1[23:16];
      acc = r1[31:24];
      // Every fifth pass drives an all-zero result
      if (i % 5 == 0) begin
        k = 8'h00;
        mv = 8'h00;
        acc = 8'h00;
      end
      bank = r2[3:0];
      ptr[2] = r2[15:4];
      flags = r2[17:16];
      apb(1'b1, olx_pkg::OLX_CTRL_OFS, {31'h0, ext});
      apb(1'b1, olx_pkg::OLX_BANK_OFS, {28'h0, bank});
      apb(1'b1, 8'(olx_pkg::OLX_PTR0_OFS + 8), {20'h0, ptr[2]});
      apb(1'b1, olx_pkg::OLX_ACC_OFS, {24'h0, acc});
      apb(1'b1, olx_pkg::OLX_STATUS_OFS, {30'h0, flags});
      apb(1'b1, olx_pkg::OLX_MADDR_OFS, {20'h0, faddr(f, av)});
      apb(1'b1, olx_pkg::OLX_MDATA_OFS, {24'h0, mv});
      if (op == 0) begin
        res = acc | k;
        w1 = {olx_pkg::OLX_ORLIT_OP, k};
      end else if (op == 1) begin
        res = acc | mv;
        w1 = {olx_pkg::OLX_ORREG_OP, dv, av, f};
      end else begin
        res = mv;
        w1 = {olx_pkg::OLX_COPY_OP, dv, av, f};
      end
      exec({16'h0000, w1}, 4);
      if (op == 0 || !dv) acc = res;
      else mv = res;
      flags = {res == 8'h00, res[7]};
      rdchk(olx_pkg::OLX_ACC_OFS, {24'h0, acc});
      rdchk(olx_pkg::OLX_MDATA_OFS, {24'h0, mv});
      apb(1'b0, olx_pkg::OLX_STATUS_OFS, 32'h0);
      chk(rd[2:0], {1'b0, flags});
    end
    // Pointer loads for every pointer field, flags preset at random
    for (int i = 0; i < 4; i++) begin
      r1 = $random(seed);
      flags = r1[13:12];
      apb(1'b1, olx_pkg::OLX_STATUS_OFS, {30'h0, flags});
      w1 = {olx_pkg::OLX_LDPTR_OP, 2'(i), r1[11:8]};
      exec({r1[31:24], r1[7:0], w1}, 8);
      // Field value 3 names no pointer and writes nothing
      if (i < 3) ptr[i] = r1[11:0];
      for (int j = 0; j < 3; j++) begin
        rdchk(8'(olx_pkg::OLX_PTR0_OFS + 4 * j), {20'h0, ptr[j]});
      end
      apb(1'b0, olx_pkg::OLX_STATUS_OFS, 32'h0);
      chk(rd[1:0], flags);
    end
    // Undecodable word: four-cycle no-op that only raises the status marker
    exec(32'h0000_FFFF, 4);
    rdchk(olx_pkg::OLX_ACC_OFS, {24'h0, acc});
    apb(1'b0, olx_pkg::OLX_STATUS_OFS, 32'h0);
    chk(rd[3:0], {2'b10, flags});
    // Reset in mid-run clears the marker, accumulator and pointers again
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(olx_pkg::OLX_ACC_OFS, 32'h0);
    rdchk(olx_pkg::OLX_STATUS_OFS, 32'h0);
    for (int j = 0; j < 3; j++) rdchk(8'(olx_pkg::OLX_PTR0_OFS + 4 * j), 32'h0);
    close_out();
  end
endmodule // olx_exec_bench

// [olx_file_ram.sv]
// Byte-wide file memory, one write port and one combinational read port
`timescale 1ns/1ps
module olx_file_ram #(
  parameter int ADDR_W = 12  // 4096-byte data space
) (
  input  wire logic              ref_clk,
  input  wire logic              we,     // Write strobe
  input  wire logic [ADDR_W-1:0] addr,   // Shared read/write address
  input  wire logic [7:0]        wdata,  // Write byte
  output logic      [7:0]        rdata   // Read byte
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];  // Storage; contents undefined at power-up

  // Write port; no reset so the array maps onto RAM
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule // olx_file_ram

// [olx_phase_seq.sv]
// Four-phase instruction cycle sequencer, one or two cycles per instruction
`timescale 1ns/1ps
module olx_phase_seq (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       start,     // Launch pulse
  input  wire logic       twoCycle,  // Two-word instruction
  output logic      [3:0] phase,     // One-hot Q1..Q4
  output logic            second,    // Second instruction cycle
  output logic            busy       // Any phase active
);
  olx_pkg::olx_phase_t stateQ;  // One-hot sequencer state
  logic                twoQ;    // Latched length of the running instruction

  // State register; Q4 either ends or rolls into a second cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= olx_pkg::OLX_IDLE;
    end else begin
      case (stateQ)
        olx_pkg::OLX_IDLE: stateQ <= start ? olx_pkg::OLX_Q1 : olx_pkg::OLX_IDLE;
        olx_pkg::OLX_Q1:   stateQ <= olx_pkg::OLX_Q2;
        olx_pkg::OLX_Q2:   stateQ <= olx_pkg::OLX_Q3;
        olx_pkg::OLX_Q3:   stateQ <= olx_pkg::OLX_Q4;
        olx_pkg::OLX_Q4:   stateQ <= (twoQ && !second) ? olx_pkg::OLX_Q1 : olx_pkg::OLX_IDLE;
        default:           stateQ <= olx_pkg::OLX_IDLE;
      endcase
    end
  end

  // Length captured at launch, held to the end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      twoQ <= 1'b0;
    end else if (start && stateQ == olx_pkg::OLX_IDLE) begin
      twoQ <= twoCycle;
    end
  end

  // Cycle index toggles at the Q4 boundary of a two-word instruction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second <= 1'b0;
    end else if (stateQ == olx_pkg::OLX_Q4) begin
      second <= twoQ && !second;
    end
  end

  assign phase = stateQ[4:1];
  assign busy  = !stateQ[0];
endmodule // olx_phase_seq

// [olx_pkg.sv]
// Shared constants and types for the OR / copy / pointer-load execute block
package olx_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] OLX_CTRL_OFS   = 8'h00;  // Extended-set enable
  localparam logic [7:0] OLX_INSTR_OFS  = 8'h04;  // Instruction launch
  localparam logic [7:0] OLX_STATUS_OFS = 8'h08;  // Flags and busy
  localparam logic [7:0] OLX_ACC_OFS    = 8'h0C;  // Accumulator
  localparam logic [7:0] OLX_BANK_OFS   = 8'h10;  // Bank pointer
  localparam logic [7:0] OLX_PTR0_OFS   = 8'h14;  // Pointers 0..2 follow in words
  localparam logic [7:0] OLX_MADDR_OFS  = 8'h20;  // File memory window address
  localparam logic [7:0] OLX_MDATA_OFS  = 8'h24;  // File memory window data
  // Field positions
  localparam int OLX_EXT_BIT   = 0;   // CTRL: extended instruction set
  localparam int OLX_NEG_BIT   = 0;   // STATUS: result MSB flag
  localparam int OLX_ZERO_BIT  = 1;   // STATUS: all-clear flag
  localparam int OLX_BUSY_BIT  = 2;   // STATUS: sequencer running
  localparam int OLX_BAD_BIT   = 3;   // STATUS: last word undecodable
  localparam int OLX_DEST_BIT  = 9;   // Destination-select bit
  localparam int OLX_BANKS_BIT = 8;   // Bank-select bit
  // Reset values
  localparam logic [7:0]  OLX_ACC_RST  = 8'h00;
  localparam logic [3:0]  OLX_BANK_RST = 4'h0;
  localparam logic [11:0] OLX_PTR_RST  = 12'h000;
  // Opcode patterns
  localparam logic [7:0] OLX_ORLIT_OP  = 8'h09;        // word[15:8]
  localparam logic [5:0] OLX_ORREG_OP  = 6'b000100;    // word[15:10]
  localparam logic [5:0] OLX_COPY_OP   = 6'b010100;    // word[15:10]
  localparam logic [9:0] OLX_LDPTR_OP  = 10'b1110111000; // word[15:6]
  // Addressing
  localparam logic [7:0] OLX_INDEX_MAX    = 8'h5F;  // Indexed window top
  localparam logic [7:0] OLX_ACCESS_SPLIT = 8'h80;  // Upper half maps high
  localparam logic [3:0] OLX_ACCESS_HIGH  = 4'hF;   // High access page
  localparam logic [3:0] OLX_ACCESS_LOW   = 4'h0;   // Low access page
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    OLX_IDLE = 5'h01, OLX_Q1 = 5'h02, OLX_Q2 = 5'h04, OLX_Q3 = 5'h08, OLX_Q4 = 5'h10
  } olx_phase_t;
endpackage
